// >>> design/glhp_pkg.sv
// Purpose: Shared constants for the graphic display host port
// Assumes: 20 MHz clk, synchronous active-high rst
// Notes:   Instruction codes, status bit positions, geometry
package glhp_pkg;

   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int PAGE_W  = 3;
   localparam int COL_W   = 6;
   localparam int LINE_W  = 6;
   localparam int DATA_W  = 8;
   localparam int ADDR_W  = PAGE_W + COL_W;
   localparam int HALVES  = 2;

   // ----------------------------------------
   // Instruction decode
   // ----------------------------------------
   localparam logic [6:0] OP_ONOFF   = 7'h1f;
   localparam logic [4:0] OP_PAGE    = 5'h17;
   localparam logic [1:0] OP_COLUMN  = 2'h1;
   localparam logic [1:0] OP_START   = 2'h3;

   // ----------------------------------------
   // Status bit positions
   // ----------------------------------------
   localparam int ST_BUSY  = 7;
   localparam int ST_OFF   = 5;
   localparam int ST_RESET = 4;

   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [LINE_W-1:0] START_RST = 6'h00;
   localparam logic [COL_W-1:0]  COL_LAST  = 6'h3f;
   localparam logic [COL_W-1:0]  COL_ZERO  = 6'h00;
   localparam logic [PAGE_W-1:0] PAGE_ZERO = 3'h0;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam int CLK_HZ       = 20_000_000;
   localparam int BUSY_NS      = 100;
   localparam int BUSY_CYC     =
      (BUSY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   typedef enum logic [1:0] {
      GLHP_ACC_INSTR,
      GLHP_ACC_STATUS,
      GLHP_ACC_WRITE,
      GLHP_ACC_READ
   } glhp_acc_t;

endpackage : glhp_pkg

// >>> design/glhp_ram.sv
// Purpose: Display data memory of one column controller
// Assumes: One write port, one registered read port
// Notes:   Read data appear one clock after the address
module glhp_ram
   import glhp_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   // Clock
   input  wire logic          clk,
   // Write port
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   // Read port
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule : glhp_ram

// >>> design/glhp_port.sv
// Purpose: Parallel host port and display control of a 128x64 module
// Assumes: Host pins synchronous to clk; two column controllers
// Notes:   Each half keeps its own flags, page, column and start line
//
// Functional notes
// - With neither select active, transfers are ignored, state unchanged.
// - Reset input acts regardless of both select inputs.
// - Write data latched on strobe fall, then stored to RAM internally.
// - Access type from register select and read/write, four codes.
// - Data read returns previously captured byte; dummy read needed.
// - Reset turns display off, blanks segments, clears start line.
// - During reset only status reads; reset shown on data bit 4.
// - Busy flag on data bit 7, high during internal operation.
// - Display off drives non-selected segments; state on data bit 5.
// - On/off instruction 0011111x switches display, nothing else.
// - Page register loaded only by set page, never counts.
// - Set column instruction 01xxxxxx loads column counter.
// - Column counter increments after each data read or write.
// - Start line instruction 11xxxxxx latches top displayed line.
// - RAM bit one lights a dot, zero leaves it dark.
// - Status: busy bit 7, off bit 5, reset bit 4, others zero.
// - Two active-high selects each enable one column controller.
module glhp_port
   import glhp_pkg::*;
#(
   parameter int BUSY_CYCLES = BUSY_CYC
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // Host bus
   input  wire logic                reset_in_n,
   input  wire logic                left_half_select,
   input  wire logic                right_half_select,
   input  wire logic                register_select,
   input  wire logic                read_write,
   input  wire logic                enable,
   input  wire logic [DATA_W-1:0]   data_in,
   output logic      [DATA_W-1:0]   data_out,
   output logic                     data_oe,
   // Display scan side
   input  wire logic [LINE_W-1:0]   scan_row,
   input  wire logic [COL_W-1:0]    scan_col,
   output logic      [HALVES-1:0]   seg_dot,
   output logic      [HALVES-1:0]   display_on
);

   localparam int BW = $clog2(BUSY_CYCLES + 1);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic                 en_q;
      logic                 on;
      logic [PAGE_W-1:0]    page;
      logic [COL_W-1:0]     col;
      logic [LINE_W-1:0]    start;
      logic [DATA_W-1:0]    in_reg;
      logic [DATA_W-1:0]    out_reg;
      logic                 store;
      logic                 fetch;
      logic [BW-1:0]        busy_cnt;
      logic [DATA_W-1:0]    dout;
      logic [HALVES-1:0]    seg;
   } glhp_half_t;

   typedef struct packed {
      glhp_half_t [HALVES-1:0] h;
      logic                    en_q;
   } glhp_state_t;

   glhp_state_t st;
   glhp_state_t next_st;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic glhp_acc_t glhp_decode(input logic rs,
                                             input logic rw);
      glhp_acc_t a;
      a = glhp_acc_t'({rs, rw});
      return a;
   endfunction : glhp_decode

   function automatic logic [COL_W-1:0] glhp_col_step(
      input logic [COL_W-1:0] c);
      logic [COL_W-1:0] n;
      n = (c == COL_LAST) ? COL_ZERO : c + 6'h01;
      return n;
   endfunction : glhp_col_step

   // ----------------------------------------
   // Memories, one per half
   // ----------------------------------------
   logic [HALVES-1:0]            sel;
   logic [HALVES-1:0]            ram_we;
   logic [ADDR_W-1:0]            ram_waddr [HALVES];
   logic [ADDR_W-1:0]            ram_raddr [HALVES];
   logic [DATA_W-1:0]            ram_rdata [HALVES];
   logic [PAGE_W-1:0]            scan_page [HALVES];
   logic [LINE_W-1:0]            scan_line [HALVES];
   logic                         fall;
   logic                         in_reset;
   glhp_acc_t                    acc;

   assign sel      = {right_half_select, left_half_select};
   assign fall     = st.en_q && !enable;
   assign in_reset = !reset_in_n;
   assign acc      = glhp_decode(register_select, read_write);

   genvar g;
   generate
      for (g = 0; g < HALVES; g++) begin : g_half
         // Fetch address goes out on the strobe edge itself, since
         // the RAM answers one clock after it sees the address
         assign scan_line[g] = scan_row + st.h[g].start;
         assign scan_page[g] = scan_line[g][LINE_W-1:LINE_W-PAGE_W];
         assign ram_we[g]    = st.h[g].store;
         assign ram_waddr[g] = {st.h[g].page, st.h[g].col};
         assign ram_raddr[g] = next_st.h[g].fetch
                               ? {st.h[g].page, st.h[g].col}
                               : {scan_page[g], scan_col};
         glhp_ram u_ram (
            .clk   (clk),
            .we    (ram_we[g]),
            .waddr (ram_waddr[g]),
            .wdata (st.h[g].in_reg),
            .raddr (ram_raddr[g]),
            .rdata (ram_rdata[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st      = st;
      next_st.en_q = enable;
      for (int i = 0; i < HALVES; i++) begin
         next_st.h[i].en_q  = enable;
         next_st.h[i].store = 1'b0;
         next_st.h[i].fetch = 1'b0;
         if (st.h[i].busy_cnt != '0) begin
            next_st.h[i].busy_cnt = st.h[i].busy_cnt - 1'b1;
         end
         // Deferred RAM write, then column advance
         if (st.h[i].store) begin
            next_st.h[i].col = glhp_col_step(st.h[i].col);
         end
         // Fetch result lands in output register one clock later
         if (st.h[i].fetch) begin
            next_st.h[i].out_reg = ram_rdata[i];
            next_st.h[i].col = glhp_col_step(st.h[i].col);
         end
         // Segment drive from the scanned RAM bit
         next_st.h[i].seg = {1'b0,
            st.h[i].on && !in_reset &&
            ram_rdata[i][scan_line[i][PAGE_W-1:0]]};
         if (in_reset) begin
            next_st.h[i].on    = 1'b0;
            next_st.h[i].start = START_RST;
         end
         // Read data are presented while the strobe is high
         if (sel[i] && enable && read_write) begin
            if (acc == GLHP_ACC_STATUS) begin
               next_st.h[i].dout = BYTE_ZERO;
               next_st.h[i].dout[ST_BUSY]  =
                  (st.h[i].busy_cnt != '0);
               next_st.h[i].dout[ST_OFF]   = !st.h[i].on;
               next_st.h[i].dout[ST_RESET] = in_reset;
            end else if (!in_reset) begin
               next_st.h[i].dout = st.h[i].out_reg;
            end
         end
         // Transfers act on the falling strobe edge only
         if (fall && sel[i] && !in_reset) begin
            next_st.h[i].busy_cnt = BW'(BUSY_CYCLES);
            case (acc)
               GLHP_ACC_INSTR: begin
                  if (data_in[7:1] == OP_ONOFF) begin
                     next_st.h[i].on = data_in[0];
                  end else if (data_in[7:3] == OP_PAGE) begin
                     next_st.h[i].page = data_in[2:0];
                  end else if (data_in[7:6] == OP_COLUMN) begin
                     next_st.h[i].col = data_in[5:0];
                  end else if (data_in[7:6] == OP_START) begin
                     next_st.h[i].start = data_in[5:0];
                  end
               end
               GLHP_ACC_WRITE: begin
                  next_st.h[i].in_reg = data_in;
                  next_st.h[i].store  = 1'b1;
               end
               GLHP_ACC_READ: begin
                  next_st.h[i].fetch = 1'b1;
               end
               GLHP_ACC_STATUS: begin
                  next_st.h[i].busy_cnt = st.h[i].busy_cnt;
               end
               default: begin
                  next_st.h[i].fetch = 1'b0;
               end
            endcase
         end
      end
      if (rst) begin
         next_st = '0;
      end
   end

   always_ff @(posedge clk) begin
      st <= next_st;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_comb begin
      data_out = BYTE_ZERO;
      data_oe  = 1'b0;
      for (int i = 0; i < HALVES; i++) begin
         if (sel[i] && read_write && enable) begin
            data_out = data_out | st.h[i].dout;
            data_oe  = 1'b1;
         end
         seg_dot[i]    = st.h[i].seg[0];
         display_on[i] = st.h[i].on;
      end
   end

endmodule : glhp_port

// >>> verification/glhp_port_asserts.sv
// Purpose: Port-level checks of the display host port
// Assumes: One clock domain, bound to glhp_port
// Notes:   Status checks wait one clock into the strobe
module glhp_port_asserts
   import glhp_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              reset_in_n,
   input wire logic              left_half_select,
   input wire logic              right_half_select,
   input wire logic              register_select,
   input wire logic              read_write,
   input wire logic              enable,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic              data_oe,
   input wire logic [HALVES-1:0] seg_dot,
   input wire logic [HALVES-1:0] display_on
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic sel = left_half_select | right_half_select;
   wire logic st = sel & enable & read_write & !register_select;

   a_oe_decode: assert property (data_oe == (sel & read_write & enable))
      else $error("output enable wrong");
   a_reset_dark: assert property (!reset_in_n |=> display_on == 2'b00)
      else $error("display on during reset");
   a_reset_blank: assert property (!reset_in_n [*3] |-> seg_dot == 2'b00)
      else $error("segments lit during reset");
   a_nosel_hold: assert property (!sel && reset_in_n && $past(reset_in_n)
      |=> $stable(display_on))
      else $error("state changed without select");
   a_onoff_cmd: assert property ($fell(enable) && left_half_select
      && !register_select && !read_write && reset_in_n
      && data_in[7:1] == OP_ONOFF |=> display_on[0] == $past(data_in[0]))
      else $error("on off instruction missed");
   a_off_dark: assert property (!display_on[0] [*3] |-> !seg_dot[0])
      else $error("dot lit while off");
   a_stat_zero: assert property (st && $past(enable)
      |-> data_out[6] == 1'b0 && data_out[3:0] == 4'h0)
      else $error("status zero bits set");
   a_stat_reset: assert property (st && $past(enable) && !reset_in_n
      && !$past(reset_in_n) |-> data_out[ST_RESET])
      else $error("reset bit not shown");
   a_stat_off: assert property (st && $past(enable) && !right_half_select
      && $stable(display_on) |-> data_out[ST_OFF] == !display_on[0])
      else $error("off bit wrong");
endmodule : glhp_port_asserts

bind glhp_port glhp_port_asserts chk (.*);

// >>> verification/glhp_host.sv
// Purpose: Host processor model on the 8-bit parallel bus
// Assumes: One access at a time, strobe held two clocks
// Notes:   Bus shows the inverse of the last byte when released
module glhp_host
   import glhp_pkg::*;
(
   input wire logic              clk,
   input wire logic [DATA_W-1:0] data_out,
   output logic                  left_half_select,
   output logic                  right_half_select,
   output logic                  register_select,
   output logic                  read_write,
   output logic                  enable,
   output logic [DATA_W-1:0]     data_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {left_half_select, right_half_select, enable} = 3'h0;
      {register_select, read_write} = 2'h0;
      data_in = 8'h00;
   end

   task automatic acc(input logic [1:0] s, input logic rs, rw,
                      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      #1;
      {right_half_select, left_half_select} = s;
      {register_select, read_write} = {rs, rw};
      data_in = d;
      enable = 1'b1;
      repeat (2) @(negedge clk);
      q = data_out;
      @(posedge clk);
      #1;
      enable = 1'b0;
      @(posedge clk);
      #1;
      {right_half_select, left_half_select} = 2'b00;
      data_in = ~d;
      repeat (4) @(posedge clk);
      #1;
   endtask : acc
endmodule : glhp_host

// >>> verification/glhp_port_tb.sv
// Purpose: Self-checking bench of the display host port
// Assumes: Host model drives the bus, bench drives reset and scan
// Notes:   Dot checks wait four clocks for the scan pipeline
module glhp_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import glhp_pkg::*;
   logic              clk = 0, rst = 1, reset_in_n = 1;
   logic              left_half_select, right_half_select;
   logic              register_select, read_write, enable, data_oe;
   logic [DATA_W-1:0] data_in, data_out, q;
   logic [LINE_W-1:0] scan_row = 0;
   logic [COL_W-1:0]  scan_col = 0;
   logic [HALVES-1:0] seg_dot, display_on;
   int                err_count = 0, cmp_count = 0;
   always #25 clk = ~clk;
   glhp_host host (.*);
   glhp_port dut (.*);

   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   task chk(input string n, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task ins(input logic [1:0] s, input logic [7:0] d);
      host.acc(s, 1'b0, 1'b0, d, q);
   endtask : ins
   task stat(input logic [1:0] s, input logic [7:0] e);
      host.acc(s, 1'b0, 1'b1, 8'h00, q);
      chk("status", e, q);
   endtask : stat
   task wr(input logic [7:0] d);
      host.acc(2'b01, 1'b1, 1'b0, d, q);
   endtask : wr
   task rd(input logic [7:0] e);
      host.acc(2'b01, 1'b1, 1'b1, 8'h00, q);
      chk("data", e, q);
   endtask : rd
   task dot(input logic e);
      tick(4);
      chk("dot", {7'h00, e}, {7'h00, seg_dot[0]});
   endtask : dot

   task t_onoff;
      stat(2'b01, 8'h20);
      ins(2'b01, 8'h3f);
      chk("on", 8'h01, {6'h00, display_on});
      stat(2'b01, 8'h00);
      stat(2'b10, 8'h20);
      ins(2'b00, 8'h3e);
      chk("on", 8'h01, {6'h00, display_on});
      $display("test onoff done");
   endtask : t_onoff
   task t_wrap;
      ins(2'b01, 8'hb8);
      ins(2'b01, 8'h7f);
      wr(8'ha5);
      wr(8'h3c);
      ins(2'b01, 8'h7f);
      host.acc(2'b01, 1'b1, 1'b1, 8'h00, q);
      rd(8'ha5);
      rd(8'h3c);
      $display("test wrap done");
   endtask : t_wrap
   task t_scroll;
      ins(2'b01, 8'h41);
      wr(8'h02);
      ins(2'b01, 8'hc0);
      scan_col = 6'h01;
      dot(1'b0);
      scan_row = 6'h01;
      dot(1'b1);
      ins(2'b01, 8'hc1);
      scan_row = 6'h00;
      dot(1'b1);
      $display("test scroll done");
   endtask : t_scroll
   task t_devreset;
      reset_in_n = 1'b0;
      tick(3);
      chk("on", 8'h00, {6'h00, display_on});
      stat(2'b01, 8'h30);
      ins(2'b01, 8'h3f);
      chk("on", 8'h00, {6'h00, display_on});
      reset_in_n = 1'b1;
      stat(2'b01, 8'h20);
      ins(2'b01, 8'h3f);
      scan_row = 6'h01;
      dot(1'b1);
      $display("test device reset done");
   endtask : t_devreset

   initial begin
      tick(20);
      rst = 1'b0;
      t_onoff;
      t_wrap;
      t_scroll;
      t_devreset;
      print_verdict;
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      print_verdict;
   end
endmodule : glhp_port_tb
